// file: rtl/sspfe_socket.sv
// How it works
// [RULE1] Unrecognized card sets bit 7 until valid card
// [RULE2] Bit 6 follows ready/irq pin level
// [RULE3] Type bits 5,4 refresh only on interrogation
// [RULE4] Bit 3 shows socket powered state
// [RULE5] Bits 2,1 follow detect pins, frozen while probing
// [RULE6] Bit 0 follows status-change pin level
// [RULE7] Context bits: bus reset clears unless power events enabled
// [RULE8] Force register at 0Ch, bits 31-15 zero
// [RULE9] Force bit 14 reinterrogates, re-enables auto power
// [RULE10] Software writes bit 14 when reprobe needed
// [RULE11] Force bits 13-10 set caps, disable auto power
// [RULE12] Force bits 9,8,7,5,4 set state bits
// [RULE13] Force bit 6 reserved, reads zero
// [RULE14] Force bit 3 sets power event only
// [RULE15] Force bits 2,1,0 set events only
// [RULE16] Caps update at insertion or force
// [RULE17] Masked events raise the socket interrupt
// [RULE18] Force reads zero; writes act one cycle
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sspfe_socket
  import sspfe_pkg::*;
#(
  parameter int PROBE_CYCLES = INTERROG_CYCLES,
  parameter logic [3:0] SOCK_CAP = SOCK_CAP_RST
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic bus_rst_n,
  input wire logic pm_event_en,
  input wire sspfe_bus_s bus_req,
  output logic [31:0] rd_data_r,
  input wire logic ready_irq_pin,
  input wire logic detect_pin_a,
  input wire logic detect_pin_b,
  input wire logic status_change_pin,
  input wire logic socket_power_on,
  input wire sspfe_card_s card_sense,
  output logic socket_change_interrupt_r,
  output logic auto_power_en_r,
  output logic interrog_busy_r
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ctx_clr; // Clear for power-management context bits
  logic force_wr; // One-cycle strobe of a force write
  logic [31:0] fdat; // Force write data
  logic ready_irq_level_r; // State bit 6
  logic status_change_level_r; // State bit 0
  logic detect_pin_a_level_r; // State bit 1
  logic detect_pin_b_level_r; // State bit 2
  logic socket_powered_r; // State bit 3
  logic cb_type_detected_r; // State bit 5
  logic narrow_type_detected_r; // State bit 4
  logic unrecognized_inserted_r; // State bit 7
  logic removal_loss_flag_r; // State bit 8
  logic bad_supply_request_r; // State bit 9
  logic [3:0] volt_cap_r; // State bits 13..10
  logic pin_a_q_r; // Raw detect A, previous cycle
  logic pin_b_q_r; // Raw detect B, previous cycle
  logic insert_seen; // Both detect pins now low, at least one was high last cycle
  logic probe_start; // Start of an interrogation
  logic probe_done; // Interrogation finished, pulse
  sspfe_card_s probe_result; // Interrogation outcome
  logic [EV_W-1:0] ev_r; // Sticky socket events
  logic [EV_W-1:0] ev_hw; // Events raised by hardware this cycle
  logic [EV_W-1:0] ev_set; // All events raised this cycle
  logic [EV_W-1:0] mask_r; // Interrupt mask
  logic [31:0] state_word; // Assembled present state
  logic [31:0] rd_data_nxt; // Read mux

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign ctx_clr = !nrst || (!bus_rst_n && !pm_event_en); // [RULE7]
  assign force_wr = bus_req.wr && (bus_req.addr == OFS_FORCE); // [RULE18]
  assign fdat = bus_req.wdata;
  assign insert_seen = !detect_pin_a && !detect_pin_b && (pin_a_q_r || pin_b_q_r);
  assign probe_start = insert_seen || (force_wr && fdat[B_REINT]); // [RULE9]

  // ----------------------------------------------------------------
  // Interrogation sequencer
  // ----------------------------------------------------------------
  sspfe_interrog #(
    .CYCLES(PROBE_CYCLES)
  ) u_probe (
    .sys_clk(sys_clk),
    .clear_n(nrst),
    .start(probe_start),
    .sense(card_sense),
    .busy_r(interrog_busy_r),
    .done_r(probe_done),
    .result_r(probe_result)
  );

  // ----------------------------------------------------------------
  // Live pin levels, not context bits
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ready_irq_level_r <= 1'b0;
      status_change_level_r <= 1'b0;
      pin_a_q_r <= 1'b1;
      pin_b_q_r <= 1'b1;
    end else begin
      ready_irq_level_r <= ready_irq_pin; // [RULE2]
      status_change_level_r <= status_change_pin; // [RULE6]
      pin_a_q_r <= detect_pin_a;
      pin_b_q_r <= detect_pin_b;
    end
  end

  // ----------------------------------------------------------------
  // Detect and power levels, context bits
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ctx_clr) begin
      // Empty-socket level, so no false detect event follows a reset
      detect_pin_a_level_r <= DETECT_RST;
      detect_pin_b_level_r <= DETECT_RST;
      socket_powered_r <= 1'b0;
    end else begin
      // Force writes never touch these levels
      socket_powered_r <= socket_power_on; // [RULE4] [RULE14]
      // Frozen while the probe uses the pins
      if (!interrog_busy_r) begin
        detect_pin_a_level_r <= detect_pin_a; // [RULE5] [RULE15]
        detect_pin_b_level_r <= detect_pin_b; // [RULE5] [RULE15]
      end
    end
  end

  // ----------------------------------------------------------------
  // Card type and unrecognized flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ctx_clr) begin
      cb_type_detected_r <= 1'b0;
      narrow_type_detected_r <= 1'b0;
      unrecognized_inserted_r <= 1'b0;
    end else begin
      // Probe outcome; a set by force in the same cycle still wins
      if (probe_done) begin
        cb_type_detected_r <= probe_result.cb; // [RULE3]
        narrow_type_detected_r <= probe_result.narrow; // [RULE3]
        unrecognized_inserted_r <= probe_result.unrecog; // [RULE1]
      end
      if (force_wr && fdat[B_CB]) begin
        cb_type_detected_r <= 1'b1; // [RULE12]
      end
      if (force_wr && fdat[B_NARROW]) begin
        narrow_type_detected_r <= 1'b1; // [RULE12]
      end
      if (force_wr && fdat[B_UNREC]) begin
        unrecognized_inserted_r <= 1'b1; // [RULE12]
      end
    end
  end

  // ----------------------------------------------------------------
  // Loss and bad supply flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ctx_clr) begin
      removal_loss_flag_r <= 1'b0;
      bad_supply_request_r <= 1'b0;
    end else begin
      if (force_wr && fdat[B_LOSS]) begin
        removal_loss_flag_r <= 1'b1; // [RULE12]
      end
      if (force_wr && fdat[B_BADSUP]) begin
        bad_supply_request_r <= 1'b1; // [RULE12]
      end
    end
  end

  // ----------------------------------------------------------------
  // Card voltage capabilities, one bit per capability
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cap
      always_ff @(posedge sys_clk) begin
        if (ctx_clr) begin
          volt_cap_r[gi] <= CAP_RST[gi];
        end else if (force_wr && fdat[B_CAP_LO + gi]) begin
          volt_cap_r[gi] <= 1'b1; // [RULE11] [RULE16]
        end else if (probe_done) begin
          volt_cap_r[gi] <= probe_result.caps[gi]; // [RULE16]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Automatic socket power control enable
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ctx_clr) begin
      auto_power_en_r <= AUTO_PWR_RST;
    end else if (force_wr && (|fdat[B_CAP_HI:B_CAP_LO])) begin
      auto_power_en_r <= 1'b0; // [RULE11]
    end else if (force_wr && fdat[B_REINT]) begin
      auto_power_en_r <= 1'b1; // [RULE9] [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // Event sources: pin changes, power changes and force bits
  // ----------------------------------------------------------------
  always_comb begin
    ev_hw = '0;
    ev_hw[B_PWR] = socket_power_on != socket_powered_r;
    ev_hw[B_CDB] = !interrog_busy_r && (detect_pin_b != detect_pin_b_level_r);
    ev_hw[B_CDA] = !interrog_busy_r && (detect_pin_a != detect_pin_a_level_r);
    ev_hw[B_STS] = status_change_pin && !status_change_level_r;
  end

  assign ev_set = ev_hw | (force_wr ? fdat[EV_W-1:0] : '0); // [RULE14] [RULE15]

  // ----------------------------------------------------------------
  // Sticky events: write one clears, a new event wins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ctx_clr) begin
      ev_r <= EVENT_RST;
    end else if (bus_req.wr && bus_req.addr == OFS_EVENT) begin
      ev_r <= (ev_r & ~fdat[EV_W-1:0]) | ev_set;
    end else begin
      ev_r <= ev_r | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // Mask register and interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ctx_clr) begin
      mask_r <= MASK_RST;
    end else if (bus_req.wr && bus_req.addr == OFS_MASK) begin
      mask_r <= fdat[EV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      socket_change_interrupt_r <= 1'b0;
    end else begin
      socket_change_interrupt_r <= |(ev_r & mask_r); // [RULE17]
    end
  end

  // ----------------------------------------------------------------
  // Read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    state_word = WORD_ZERO;
    state_word[B_SOCK_HI:B_SOCK_LO] = SOCK_CAP;
    state_word[B_CAP_HI:B_CAP_LO] = volt_cap_r;
    state_word[B_BADSUP] = bad_supply_request_r;
    state_word[B_LOSS] = removal_loss_flag_r;
    state_word[B_UNREC] = unrecognized_inserted_r;
    state_word[B_RDY] = ready_irq_level_r;
    state_word[B_CB] = cb_type_detected_r;
    state_word[B_NARROW] = narrow_type_detected_r;
    state_word[B_PWR] = socket_powered_r;
    state_word[B_CDB] = detect_pin_b_level_r;
    state_word[B_CDA] = detect_pin_a_level_r;
    state_word[B_STS] = status_change_level_r;
  end

  always_comb begin
    rd_data_nxt = WORD_ZERO;
    case (bus_req.addr)
      OFS_EVENT: rd_data_nxt[EV_W-1:0] = ev_r;
      OFS_MASK: rd_data_nxt[EV_W-1:0] = mask_r;
      OFS_STATE: rd_data_nxt = state_word;
      OFS_FORCE: rd_data_nxt = WORD_ZERO; // [RULE8] [RULE13] [RULE18]
      default: rd_data_nxt = WORD_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_data_r <= WORD_ZERO;
    end else if (bus_req.rd) begin
      rd_data_r <= rd_data_nxt;
    end else begin
      rd_data_r <= WORD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_main @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence rd_state_s;
    bus_req.rd && bus_req.addr == OFS_STATE;
  endsequence

  sequence force_sts_s;
    force_wr && fdat[B_STS] && mask_r[B_STS] && !(bus_req.addr == OFS_MASK);
  endsequence

  chk_ready_read: assert property ( // [RULE2]
    rd_state_s |=> rd_data_r[B_RDY] == $past(ready_irq_pin, 2))
    else $error("ready level misreported");

  chk_status_read: assert property ( // [RULE6]
    rd_state_s |=> rd_data_r[B_STS] == $past(status_change_pin, 2))
    else $error("status-change level misreported");

  chk_force_reads_zero: assert property ( // [RULE8]
    bus_req.rd && bus_req.addr == OFS_FORCE |=> rd_data_r == WORD_ZERO)
    else $error("force register read not zero");

  chk_detect_frozen: assert property ( // [RULE5]
    interrog_busy_r && !ctx_clr |=> $stable(detect_pin_a_level_r) && $stable(detect_pin_b_level_r))
    else $error("detect level moved during probe");

  chk_type_hold: assert property ( // [RULE3]
    !probe_done && !force_wr && !ctx_clr |=> $stable(cb_type_detected_r) && $stable(narrow_type_detected_r))
    else $error("card type changed without probe");

  chk_cap_force: assert property ( // [RULE11]
    force_wr && fdat[B_CAP_HI] && !ctx_clr |=> volt_cap_r[3] && !auto_power_en_r)
    else $error("capability force failed");

  chk_reint_start: assert property ( // [RULE9]
    force_wr && fdat[B_REINT] && !(|fdat[B_CAP_HI:B_CAP_LO]) && !ctx_clr
      |=> auto_power_en_r && interrog_busy_r)
    else $error("reinterrogate not started");

  chk_power_event: assert property ( // [RULE14]
    force_wr && fdat[B_PWR] && !ctx_clr
      |=> ev_r[B_PWR] && socket_powered_r == $past(socket_power_on))
    else $error("power force misbehaved");

  chk_irq_raise: assert property ( // [RULE17]
    force_sts_s and !ctx_clr |=> ev_r[B_STS] ##1 socket_change_interrupt_r)
    else $error("masked event gave no interrupt");

  chk_unrecog_set: assert property ( // [RULE1]
    probe_done && probe_result.unrecog && !ctx_clr |=> unrecognized_inserted_r)
    else $error("unrecognized card not flagged");

  chk_ctx_clear: assert property ( // [RULE7]
    !bus_rst_n && !pm_event_en |=> ev_r == EVENT_RST && !unrecognized_inserted_r)
    else $error("context bits survived bus reset");

endmodule : sspfe_socket
`default_nettype wire

// file: shared/sspfe_pkg.sv
`default_nettype none
package sspfe_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_EVENT = 8'h00; // Sticky socket events, write one to clear
  localparam logic [7:0] OFS_MASK = 8'h04; // Interrupt mask, same layout
  localparam logic [7:0] OFS_STATE = 8'h08; // Present state, read only
  localparam logic [7:0] OFS_FORCE = 8'h0C; // Force event, write only

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_STS = 0; // Status-change level / event
  localparam int B_CDA = 1; // Detect pin A level / event
  localparam int B_CDB = 2; // Detect pin B level / event
  localparam int B_PWR = 3; // Socket powered / power event
  localparam int B_NARROW = 4; // 16-bit card type
  localparam int B_CB = 5; // CardBus card type
  localparam int B_RDY = 6; // Ready/irq pin level
  localparam int B_UNREC = 7; // Unrecognized card
  localparam int B_LOSS = 8; // Data loss on removal
  localparam int B_BADSUP = 9; // Bad supply request
  localparam int B_CAP_LO = 10; // Card voltage capability, low bit
  localparam int B_CAP_HI = 13; // Card voltage capability, high bit
  localparam int B_REINT = 14; // Reinterrogate trigger
  localparam int B_SOCK_LO = 28; // Socket supply capability, low bit
  localparam int B_SOCK_HI = 31; // Socket supply capability, high bit
  localparam int EV_W = 4; // Width of event and mask registers

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SOCK_CAP_RST = 4'h3; // 3.3 V and 5 V supported
  localparam logic [3:0] CAP_RST = 4'h0;
  localparam logic [EV_W-1:0] EVENT_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0; // No interrupt by default
  localparam logic AUTO_PWR_RST = 1'b1;
  localparam logic DETECT_RST = 1'b1; // Empty-socket detect level
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int INTERROG_TIME_NS = 2000; // Least duration of a card probe
  localparam int INTERROG_CYCLES = (INTERROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sspfe_bus_s;

  // Outcome of a card interrogation
  typedef struct packed {
    logic unrecog;
    logic cb;
    logic narrow;
    logic [3:0] caps;
  } sspfe_card_s;

  // Interrogation sequencer states
  typedef enum logic [1:0] {
    SSPFE_IDLE = 2'b01,
    SSPFE_PROBE = 2'b10
  } sspfe_seq_e;

endpackage : sspfe_pkg
`default_nettype wire

// file: rtl/sspfe_interrog.sv
`timescale 1ns/1ps
`default_nettype none
module sspfe_interrog
  import sspfe_pkg::*;
#(
  parameter int CYCLES = INTERROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic clear_n,
  input wire logic start,
  input wire sspfe_card_s sense,
  output logic busy_r,
  output logic done_r,
  output sspfe_card_s result_r
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES - 1);

  sspfe_seq_e state_r; // Sequencer state
  logic [CW-1:0] cnt_r; // Cycles left in the probe

  // ----------------------------------------------------------------
  // Probe sequencer: a start restarts a running probe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!clear_n) begin
      state_r <= SSPFE_IDLE;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        SSPFE_IDLE: begin
          // Wait for insertion or software request
          if (start) begin
            state_r <= SSPFE_PROBE;
            cnt_r <= CNT_LOAD;
            busy_r <= 1'b1;
          end
        end
        SSPFE_PROBE: begin
          // Count the probe time out, then report once
          if (start) begin
            cnt_r <= CNT_LOAD;
          end else if (cnt_r == '0) begin
            state_r <= SSPFE_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= SSPFE_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result capture at the end of the probe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!clear_n) begin
      result_r <= '0;
    end else if (state_r == SSPFE_PROBE && !start && cnt_r == '0) begin
      result_r <= sense;
    end
  end

endmodule : sspfe_interrog
`default_nettype wire

// file: verif/sspfe_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Card in the socket
// ----------------------------------------------------------------
module sspfe_card_model
  import sspfe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic present,
  input wire logic bounce_a,
  input wire logic rdy_lvl,
  input wire logic sts_lvl,
  input wire sspfe_card_s kind,
  output logic ready_irq_pin,
  output logic detect_pin_a,
  output logic detect_pin_b,
  output logic status_change_pin,
  output sspfe_card_s card_sense
);
  logic [6:0] held_r = 7'h00; // Last type shown while inserted
  // Keep the type of the card last inserted
  always @(posedge sys_clk) begin
    if (present) begin
      held_r <= kind;
    end
  end
  // Detect pins pulled up when empty; bounce lifts pin A mid-probe
  assign detect_pin_a = ~present | bounce_a;
  assign detect_pin_b = ~present;
  // Ready and status lines pulled down when empty
  assign ready_irq_pin = present & rdy_lvl;
  assign status_change_pin = present & sts_lvl;
  // Empty socket shows inverted stale type, never a clean copy
  assign card_sense = present ? kind : sspfe_card_s'(~held_r);
endmodule : sspfe_card_model
`default_nettype wire

// file: verif/test_socket_state_and_force_event.sv
`timescale 1ns/1ps
`default_nettype none
module test_socket_state_and_force_event;
  import sspfe_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  localparam int PC = 8; // Shortened probe length
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic bus_rst_n = 1'h1;
  logic pm_event_en = 1'h0;
  logic socket_power_on = 1'h0;
  sspfe_bus_s bus_req = '0;
  logic present = 1'h0;
  logic bounce_a = 1'h0;
  logic rdy_lvl = 1'h0;
  logic sts_lvl = 1'h0;
  sspfe_card_s kind = '0;
  logic [31:0] rd_data_r;
  logic irq, apw, busy, rp, da, db, sp;
  sspfe_card_s sense;
  logic [31:0] v;
  int errors = 0;
  int checks_done = 0;
  // Clock at 50 MHz
  always #10 sys_clk = ~sys_clk;
  sspfe_card_model sspfe_card_model_inst (.sys_clk(sys_clk), .present(present),
    .bounce_a(bounce_a), .rdy_lvl(rdy_lvl), .sts_lvl(sts_lvl), .kind(kind),
    .ready_irq_pin(rp), .detect_pin_a(da), .detect_pin_b(db), .status_change_pin(sp),
    .card_sense(sense));
  sspfe_socket #(.PROBE_CYCLES(PC)) sspfe_socket_inst (.sys_clk(sys_clk), .nrst(nrst),
    .bus_rst_n(bus_rst_n), .pm_event_en(pm_event_en), .bus_req(bus_req), .rd_data_r(rd_data_r),
    .ready_irq_pin(rp), .detect_pin_a(da), .detect_pin_b(db), .status_change_pin(sp),
    .socket_power_on(socket_power_on), .card_sense(sense), .socket_change_interrupt_r(irq),
    .auto_power_en_r(apw), .interrog_busy_r(busy));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge sys_clk);
    bus_req.wr <= 1'h0;
  endtask : wr
  // One-cycle read strobe; data stands only in the next cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'h0, rd: 1'h1};
    @(posedge sys_clk);
    bus_req.rd <= 1'h0;
    #1 d = rd_data_r;
  endtask : rd
  // Wait for a probe to finish, bounded
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    #1;
    while (busy !== 1'h0) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 50) begin
        errors++;
        wrap_up();
      end
    end
    repeat (3) @(posedge sys_clk);
  endtask : wait_idle
  // Expected state word: held bits from ctx, live bits from the pins
  function automatic logic [31:0] exp_st(input logic [31:0] ctx, input logic dlv);
    return {SOCK_CAP_RST, 14'h0000, ctx[13:7], rp, ctx[5:4], socket_power_on, dlv, dlv, sp};
  endfunction : exp_st
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'h1;
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_0000, 1'h1));
    wr(OFS_FORCE, 32'h0000_0040);
    rd(OFS_FORCE, v);
    chk_word(v, 32'h0000_0000);
    rd(8'h10, v);
    chk_word(v, 32'h0000_0000);
    // Insertion of a CardBus card, pin A bounces mid-probe
    kind <= '{unrecog: 1'h0, cb: 1'h1, narrow: 1'h0, caps: 4'h3};
    rdy_lvl <= 1'h1;
    sts_lvl <= 1'h1;
    socket_power_on <= 1'h1;
    present <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_flag(busy, 1'h1);
    bounce_a <= 1'h1;
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_0000, 1'h0));
    bounce_a <= 1'h0;
    wait_idle();
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_0C20, 1'h0));
    // New sense without a probe leaves the type alone
    kind <= '{unrecog: 1'h0, cb: 1'h0, narrow: 1'h1, caps: 4'hC};
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_0C20, 1'h0));
    wr(OFS_FORCE, 32'h0000_4000);
    wait_idle();
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_3010, 1'h0));
    // Unrecognized card, then a valid one
    kind <= '{unrecog: 1'h1, cb: 1'h0, narrow: 1'h0, caps: 4'h0};
    wr(OFS_FORCE, 32'h0000_4000);
    wait_idle();
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_0080, 1'h0));
    kind <= '{unrecog: 1'h0, cb: 1'h1, narrow: 1'h0, caps: 4'h1};
    wr(OFS_FORCE, 32'h0000_4000);
    wait_idle();
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_0420, 1'h0));
    chk_flag(apw, 1'h1);
    // Forced capabilities and flags
    wr(OFS_FORCE, 32'h0000_2800);
    #1 chk_flag(apw, 1'h0);
    wr(OFS_FORCE, 32'h0000_03F0);
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_2FB0, 1'h0));
    // Each forced event, masked then unmasked
    wr(OFS_EVENT, 32'h0000_000F);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_FORCE, 32'h0000_0001 << i);
      wr(OFS_MASK, 32'h0000_000F ^ (32'h0000_0001 << i));
      repeat (2) @(posedge sys_clk);
      #1 chk_flag(irq, 1'h0);
      rd(OFS_EVENT, v);
      chk_word(v, 32'h0000_0001 << i);
      wr(OFS_MASK, 32'h0000_0001 << i);
      repeat (2) @(posedge sys_clk);
      #1 chk_flag(irq, 1'h1);
      wr(OFS_EVENT, 32'h0000_000F);
      repeat (2) @(posedge sys_clk);
      #1 chk_flag(irq, 1'h0);
    end
    // Forced status event while already unmasked
    wr(OFS_MASK, 32'h0000_0009);
    wr(OFS_FORCE, 32'h0000_0001);
    @(posedge sys_clk);
    #1 chk_flag(irq, 1'h1);
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_2FB0, 1'h0));
    // Bus reset with and without power-management events enabled
    present <= 1'h0;
    repeat (4) @(posedge sys_clk);
    pm_event_en <= 1'h1;
    bus_rst_n <= 1'h0;
    @(posedge sys_clk);
    bus_rst_n <= 1'h1;
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_2FB0, 1'h1));
    rd(OFS_MASK, v);
    chk_word(v, 32'h0000_0009);
    pm_event_en <= 1'h0;
    bus_rst_n <= 1'h0;
    @(posedge sys_clk);
    bus_rst_n <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rd(OFS_STATE, v);
    chk_word(v, exp_st(32'h0000_0000, 1'h1));
    rd(OFS_MASK, v);
    chk_word(v, 32'h0000_0000);
    chk_flag(apw, 1'h1);
    wrap_up();
  end
endmodule : test_socket_state_and_force_event
`default_nettype wire
